// ### rtl/sram_ft_defs.svh
`ifndef SRAM_FT_DEFS_SVH
`define SRAM_FT_DEFS_SVH
// Geometry
`define SRAM_LANE_W       9
`define SRAM_LANES        4
`define SRAM_ADDR_W       10
`define SRAM_BURST_W      2
// Write buffer depth, power of two
`define SRAM_FIFO_DEPTH   8
// Sleep entry and wake-up delay in clock cycles, equal to the sync depth
`define SRAM_SLEEP_CYCLES 2
// Reset values
`define SRAM_CNT_RST      2'h0
`define SRAM_MASK_RST     4'h0
`endif

// ### rtl/sram_ft_pkg.sv
package sram_ft_pkg;
   // Command sequencer state, one-hot
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_READ  = 4'h2,
      ST_WRITE = 4'h4,
      ST_DESEL = 4'h8
   } cmd_state_e;

   // Synchronous control pins sampled on each edge
   typedef struct packed {
      logic       clock_gate_n;
      logic       counter_step_or_load;
      logic       store_select_n;
      logic [3:0] lane_write_n;
      logic       chip_select_first_n;
      logic       chip_select_hi;
      logic       chip_select_third_n;
   } cmd_pins_s;
endpackage

// ### rtl/sram_ft_core.sv
`timescale 1ns/1ps
`include "sram_ft_defs.svh"

// Posted-write buffer between late-write capture and the array
module wr_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `SRAM_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             en,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0]   cnt;
   } fifo_s;

   fifo_s            st_reg;
   fifo_s            st_next;
   logic [WIDTH-1:0] store [DEPTH];
   logic             push;
   logic             pop;

   // Flags straight from the occupancy count
   assign in_ready  = st_reg.cnt != (PW+1)'(DEPTH);
   assign out_valid = st_reg.cnt != '0;
   assign out_data  = store[st_reg.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointers wrap naturally, so DEPTH must be a power of two
   always_comb begin
      st_next     = st_reg;
      st_next.wp  = st_reg.wp + PW'(push);
      st_next.rp  = st_reg.rp + PW'(pop);
      st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else if (en) begin
         st_reg <= st_next;
      end
   end

   // Entry storage, no reset needed
   always_ff @(posedge clk) begin
      if (en && push) begin
         store[st_reg.wp] <= in_data;
      end
   end
endmodule

module sram_ft_core
   import sram_ft_pkg::*;
#(
   parameter int ADDR_W     = `SRAM_ADDR_W,
   parameter int FIFO_DEPTH = `SRAM_FIFO_DEPTH
) (
   // Clock, reset, clock enable
   input  wire logic              SYS_CLK,
   input  wire logic              RST_N,
   input  wire logic              CLK_EN,
   // Address
   input  wire logic [ADDR_W-3:0] ADDRESS_HI,
   input  wire logic [1:0]        BURST_START_BITS,
   // Synchronous control
   input  wire logic              CLOCK_GATE_N,
   input  wire logic              COUNTER_STEP_OR_LOAD,
   input  wire logic              STORE_SELECT_N,
   input  wire logic              LANE_A_WRITE_N,
   input  wire logic              LANE_B_WRITE_N,
   input  wire logic              LANE_C_WRITE_N,
   input  wire logic              LANE_D_WRITE_N,
   input  wire logic              CHIP_SELECT_FIRST_N,
   input  wire logic              CHIP_SELECT_HI,
   input  wire logic              CHIP_SELECT_THIRD_N,
   // Asynchronous control and strap
   input  wire logic              OUTPUT_ENABLE_N,
   input  wire logic              SLEEP_REQUEST,
   input  wire logic              LINEAR_ORDER_SEL_N,
   // Byte lanes, split into input, output and enable
   input  wire logic [8:0]        BYTE_LANE_A_IN,
   output logic      [8:0]        BYTE_LANE_A_OUT,
   output logic                   BYTE_LANE_A_OE,
   input  wire logic [8:0]        BYTE_LANE_B_IN,
   output logic      [8:0]        BYTE_LANE_B_OUT,
   output logic                   BYTE_LANE_B_OE,
   input  wire logic [8:0]        BYTE_LANE_C_IN,
   output logic      [8:0]        BYTE_LANE_C_OUT,
   output logic                   BYTE_LANE_C_OE,
   input  wire logic [8:0]        BYTE_LANE_D_IN,
   output logic      [8:0]        BYTE_LANE_D_OUT,
   output logic                   BYTE_LANE_D_OE,
   // Write buffer can accept the next beat
   output logic                   BUFFER_READY
);
   localparam int LW    = `SRAM_LANE_W;
   localparam int NL    = `SRAM_LANES;
   localparam int WW    = LW * NL;
   localparam int DEPTH = 1 << ADDR_W;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [NL-1:0]     mask;
      logic [WW-1:0]     data;
   } wr_entry_s;

   typedef struct packed {
      cmd_state_e        state;
      logic [ADDR_W-3:0] base;
      logic [1:0]        start;
      logic [1:0]        cnt;
      logic              drive;
      logic              pend;
      logic [ADDR_W-1:0] pend_addr;
      logic [NL-1:0]     pend_mask;
      logic              sleep_sync;
      logic              sleeping;
      logic [1:0]        order_sync;
   } core_s;

   core_s             st_reg;
   core_s             st_next;
   cmd_pins_s         cmd;
   logic [WW-1:0]     array_mem [DEPTH];
   logic [WW-1:0]     din;
   logic [WW-1:0]     rd_word;
   logic [NL-1:0]     lane_en;
   logic [ADDR_W-1:0] cur_addr;
   logic              interleave;
   logic              selected;
   logic              go;
   logic              drive_now;
   logic              buf_ready;
   logic              drain_valid;
   logic              drain_ready;
   wr_entry_s         push_entry;
   wr_entry_s         drain_entry;

   function automatic logic [1:0] burst_lo(input logic [1:0] s, input logic [1:0] c, input logic il);
      return il ? (s ^ c) : 2'(s + c);
   endfunction

   // Pack the sampled control pins
   assign cmd = '{clock_gate_n: CLOCK_GATE_N, counter_step_or_load: COUNTER_STEP_OR_LOAD,
                  store_select_n: STORE_SELECT_N,
                  lane_write_n: {LANE_D_WRITE_N, LANE_C_WRITE_N, LANE_B_WRITE_N, LANE_A_WRITE_N},
                  chip_select_first_n: CHIP_SELECT_FIRST_N, chip_select_hi: CHIP_SELECT_HI,
                  chip_select_third_n: CHIP_SELECT_THIRD_N};
   assign din = {BYTE_LANE_D_IN, BYTE_LANE_C_IN, BYTE_LANE_B_IN, BYTE_LANE_A_IN};

   // Strap is resynchronised; the board must keep it still
   assign interleave = st_reg.order_sync[1];
   assign cur_addr   = {st_reg.base, burst_lo(st_reg.start, st_reg.cnt, interleave)};
   assign selected   = !cmd.chip_select_first_n && cmd.chip_select_hi && !cmd.chip_select_third_n;
   // A full buffer stalls the edge like the clock gate does
   assign go         = !cmd.clock_gate_n && !st_reg.sleeping && buf_ready;
   assign BUFFER_READY = buf_ready;

   // Late data joins the address and mask registered one edge before
   assign push_entry = '{addr: st_reg.pend_addr, mask: st_reg.pend_mask, data: din};

   // Command sequencer
   always_comb begin
      st_next            = st_reg;
      st_next.sleep_sync = SLEEP_REQUEST;
      st_next.order_sync = {st_reg.order_sync[0], LINEAR_ORDER_SEL_N};
      // Sleeping is the second flop, so the edge ignore starts two edges after the request
      st_next.sleeping   = st_reg.sleep_sync;
      if (go) begin
         st_next.pend = 1'b0;
         if (!cmd.counter_step_or_load) begin
            if (selected) begin
               st_next.base  = ADDRESS_HI;
               st_next.start = BURST_START_BITS;
               st_next.cnt   = `SRAM_CNT_RST;
               if (cmd.store_select_n) begin
                  st_next.state = ST_READ;
                  st_next.drive = 1'b1;
               end else begin
                  st_next.state     = ST_WRITE;
                  st_next.drive     = 1'b0;
                  st_next.pend      = |(~cmd.lane_write_n);
                  st_next.pend_addr = {ADDRESS_HI, BURST_START_BITS};
                  st_next.pend_mask = ~cmd.lane_write_n;
               end
            end else begin
               st_next.state = ST_DESEL;
               st_next.drive = 1'b0;
            end
         end else begin
            // Continue ignores selects and store select
            case (st_reg.state)
               ST_READ: begin
                  st_next.cnt = st_reg.cnt + 2'h1;
               end
               ST_WRITE: begin
                  st_next.cnt       = st_reg.cnt + 2'h1;
                  st_next.pend      = |(~cmd.lane_write_n);
                  st_next.pend_addr = {st_reg.base, burst_lo(st_reg.start, st_next.cnt, interleave)};
                  st_next.pend_mask = ~cmd.lane_write_n;
               end
               default: begin
                  st_next.state = ST_DESEL;
                  st_next.drive = 1'b0;
               end
            endcase
         end
      end
   end

   // Reset doubles as power-up: nothing drives, sequencer idle
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg <= '{state: ST_IDLE, cnt: `SRAM_CNT_RST, pend_mask: `SRAM_MASK_RST, default: '0};
      end else if (CLK_EN) begin
         st_reg <= st_next;
      end
   end

   // Posted writes; reads own the array port unless the buffer is full
   wr_buffer #(
      .WIDTH (ADDR_W + NL + WW),
      .DEPTH (FIFO_DEPTH)
   ) u_wr_buffer (
      .clk       (SYS_CLK),
      .rst_n     (RST_N),
      .en        (CLK_EN),
      .in_valid  (go && st_reg.pend),
      .in_ready  (buf_ready),
      .in_data   (push_entry),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_entry)
   );
   assign drain_ready = !st_reg.sleeping && (st_reg.state != ST_READ || !buf_ready);

   // Self-timed lane writes from the buffer head
   always_ff @(posedge SYS_CLK) begin
      if (CLK_EN && drain_valid && drain_ready) begin
         for (int l = 0; l < NL; l++) begin
            if (drain_entry.mask[l]) begin
               array_mem[drain_entry.addr][l*LW +: LW] <= drain_entry.data[l*LW +: LW];
            end
         end
      end
   end

   // Flow-through read: array word follows the registered address
   assign rd_word = array_mem[cur_addr];
   // Output enable and sleep act without the clock
   assign drive_now = st_reg.drive && !OUTPUT_ENABLE_N && !SLEEP_REQUEST && !st_reg.sleeping;

   generate
      for (genvar i = 0; i < NL; i++) begin : g_lane
         assign lane_en[i] = drive_now;
      end
   endgenerate

   assign BYTE_LANE_A_OUT = rd_word[0*LW +: LW];
   assign BYTE_LANE_B_OUT = rd_word[1*LW +: LW];
   assign BYTE_LANE_C_OUT = rd_word[2*LW +: LW];
   assign BYTE_LANE_D_OUT = rd_word[3*LW +: LW];
   assign BYTE_LANE_A_OE  = lane_en[0];
   assign BYTE_LANE_B_OE  = lane_en[1];
   assign BYTE_LANE_C_OE  = lane_en[2];
   assign BYTE_LANE_D_OE  = lane_en[3];

   oe_override_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      OUTPUT_ENABLE_N |-> lane_en == '0) else $error("drivers on with output enable high");
   stall_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && CLOCK_GATE_N |=> $stable(cur_addr) && $stable(st_reg.state)) else $error("state moved on stall");
   stall_drive_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && CLOCK_GATE_N |=> st_reg.drive == $past(st_reg.drive)) else $error("drive changed on stall");
   read_begin_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && !COUNTER_STEP_OR_LOAD && selected && STORE_SELECT_N
      |=> st_reg.state == ST_READ && cur_addr == $past({ADDRESS_HI, BURST_START_BITS})) else $error("read begin");
   write_quiet_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st_reg.state == ST_WRITE |-> lane_en == '0) else $error("driving during write");
   abort_nop_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && !COUNTER_STEP_OR_LOAD && selected && !STORE_SELECT_N && cmd.lane_write_n == 4'hF
      |=> !st_reg.pend) else $error("abort left a write pending");
   deselect_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && !COUNTER_STEP_OR_LOAD && !selected |=> st_reg.state == ST_DESEL && lane_en == '0)
      else $error("deselect not taken");
   burst_step_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && COUNTER_STEP_OR_LOAD && st_reg.state inside {ST_READ, ST_WRITE}
      |=> st_reg.cnt == 2'($past(st_reg.cnt) + 2'h1)) else $error("burst counter did not step");
   sleep_release_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      SLEEP_REQUEST |-> lane_en == '0) else $error("driving while asleep");
   sleep_entry_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && SLEEP_REQUEST ##1 CLK_EN && SLEEP_REQUEST |=> st_reg.sleeping)
      else $error("sleep not entered after two cycles");
   flow_drive_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && !COUNTER_STEP_OR_LOAD && selected && STORE_SELECT_N |=> st_reg.drive)
      else $error("read begin left drivers off");
   late_write_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && !COUNTER_STEP_OR_LOAD && selected && !STORE_SELECT_N && cmd.lane_write_n != 4'hF
      |=> st_reg.pend && st_reg.pend_addr == $past({ADDRESS_HI, BURST_START_BITS}))
      else $error("write begin left no late beat pending");
   cont_mask_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && COUNTER_STEP_OR_LOAD && st_reg.state == ST_WRITE
      |=> st_reg.state == ST_WRITE && st_reg.pend_mask == ~$past(cmd.lane_write_n))
      else $error("continued write lost its lane mask");
   cont_desel_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      CLK_EN && go && COUNTER_STEP_OR_LOAD && !(st_reg.state inside {ST_READ, ST_WRITE})
      |=> st_reg.state == ST_DESEL && lane_en == '0)
      else $error("continued deselect made an access");
endmodule

// ### verif/host_ctrl_model.sv
`timescale 1ns/1ps

// Host memory controller: drives the command pins and its half of the lanes
module host_ctrl_model (
   // Clock
   input  wire logic        clk,
   // Device half of the lanes
   input  wire logic [35:0] dev_out,
   input  wire logic [3:0]  dev_oe,
   // Command pins
   output logic      [7:0]  addr_hi,
   output logic      [1:0]  start_bits,
   output logic             gate_n,
   output logic             step,
   output logic             store_n,
   output logic      [3:0]  lane_n,
   output logic      [2:0]  sel,
   // Lanes as both parties see them
   output logic      [35:0] lanes
);
   logic        host_drv   = 1'b0;
   logic [35:0] host_data  = 36'h0;
   logic [35:0] last_lanes = 36'h0;

   // Released lanes show the inverse of their last level, never a stale copy
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         if (host_drv)
            lanes[9*l+:9] = host_data[9*l+:9];
         else if (dev_oe[l])
            lanes[9*l+:9] = dev_out[9*l+:9];
         else
            lanes[9*l+:9] = ~last_lanes[9*l+:9];
      end
   end

   // Lane history for the released level
   always @(posedge clk) last_lanes <= lanes;

   // Set pins for one cycle; kind 0 read, 1 write, 2 continue, 3 deselect
   task automatic put(input logic [1:0] kind, input logic [9:0] a, input logic [3:0] m,
                      input logic dv, input logic [35:0] d, input logic g);
      addr_hi = a[9:2];
      start_bits = a[1:0];
      gate_n = g;
      lane_n = m;
      host_drv = dv;
      host_data = d;
      step = (kind == 2'h2);
      store_n = !((kind == 2'h1) || (kind == 2'h2));
      case (kind)
         2'h2: sel = 3'b101; // Continue must ignore selects, so show them inactive
         2'h3: sel = (m == 4'h0) ? 3'b110 : ((m == 4'h1) ? 3'b000 : 3'b011);
         default: sel = 3'b010;
      endcase
   endtask

   // Pins change just after an edge and hold through the taking edge
   task automatic issue(input logic [1:0] kind, input logic [9:0] a, input logic [3:0] m,
                        input logic dv = 1'b0, input logic [35:0] d = 36'h0, input logic g = 1'b0);
      put(kind, a, m, dv, d, g);
      @(posedge clk);
      #1;
   endtask
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps

module testbench;
   import sram_ft_pkg::*;
   localparam logic [1:0] RD = 2'h0;
   localparam logic [1:0] WR = 2'h1;
   localparam logic [1:0] ST = 2'h2;
   localparam logic [1:0] DS = 2'h3;
   logic        sys_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic        clk_en    = 1'b1;
   logic        oe_n      = 1'b0;
   logic        sleep_req = 1'b0;
   logic        order_n   = 1'b0;
   logic [7:0]  addr_hi;
   logic [1:0]  start_bits;
   logic        gate_n, step, store_n, buf_ready;
   logic [3:0]  lane_n, dev_oe;
   logic [2:0]  sel;
   logic [35:0] lanes, dev_out;
   logic [35:0] mem_exp [1024];
   int          fail_count = 0;
   int          n_checks   = 0;

   // Clock, 4 ns period
   always #2 sys_clk = ~sys_clk;

   host_ctrl_model host (.clk(sys_clk), .dev_out(dev_out), .dev_oe(dev_oe), .addr_hi(addr_hi),
      .start_bits(start_bits), .gate_n(gate_n), .step(step), .store_n(store_n), .lane_n(lane_n),
      .sel(sel), .lanes(lanes));

   sram_ft_core uut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(clk_en), .ADDRESS_HI(addr_hi),
      .BURST_START_BITS(start_bits), .CLOCK_GATE_N(gate_n), .COUNTER_STEP_OR_LOAD(step),
      .STORE_SELECT_N(store_n), .LANE_A_WRITE_N(lane_n[0]), .LANE_B_WRITE_N(lane_n[1]),
      .LANE_C_WRITE_N(lane_n[2]), .LANE_D_WRITE_N(lane_n[3]), .CHIP_SELECT_FIRST_N(sel[2]),
      .CHIP_SELECT_HI(sel[1]), .CHIP_SELECT_THIRD_N(sel[0]), .OUTPUT_ENABLE_N(oe_n),
      .SLEEP_REQUEST(sleep_req), .LINEAR_ORDER_SEL_N(order_n),
      .BYTE_LANE_A_IN(lanes[8:0]), .BYTE_LANE_A_OUT(dev_out[8:0]), .BYTE_LANE_A_OE(dev_oe[0]),
      .BYTE_LANE_B_IN(lanes[17:9]), .BYTE_LANE_B_OUT(dev_out[17:9]), .BYTE_LANE_B_OE(dev_oe[1]),
      .BYTE_LANE_C_IN(lanes[26:18]), .BYTE_LANE_C_OUT(dev_out[26:18]), .BYTE_LANE_C_OE(dev_oe[2]),
      .BYTE_LANE_D_IN(lanes[35:27]), .BYTE_LANE_D_OUT(dev_out[35:27]), .BYTE_LANE_D_OE(dev_oe[3]),
      .BUFFER_READY(buf_ready));

   task automatic final_report();
      if (fail_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_oe(input logic [3:0] e);
      chk({32'h0, dev_oe}, {32'h0, e});
   endtask

   // Distinct word per address within each 512-word half (bit 9 unused), seeded so rewrites differ
   function automatic logic [35:0] pat(input logic [9:0] a, input logic [8:0] s);
      pat = {a[8:0] ^ 9'h0AA, a[8:0], ~a[8:0], a[8:0] ^ 9'h155} ^ {4{s}};
   endfunction

   // Address of beat k in a burst loaded at a
   function automatic logic [9:0] baddr(input logic [9:0] a, input int k);
      logic [1:0] c;
      c = 2'(k);
      baddr = {a[9:2], order_n ? (a[1:0] ^ c) : (a[1:0] + c)};
   endfunction

   // Deselects give the posted writes time to reach the array
   task automatic drain();
      repeat (6) host.issue(DS, 10'h0, 4'h0);
   endtask

   task automatic rd(input logic [9:0] a);
      host.issue(RD, a, 4'hF);
      chk_oe(4'hF);
      chk(lanes, mem_exp[a]);
   endtask

   task automatic wr1(input logic [9:0] a, input logic [3:0] m, input logic [35:0] d);
      host.issue(WR, a, m);
      chk_oe(4'h0);
      host.issue(DS, a, 4'h0, 1'b1, d);
      for (int l = 0; l < 4; l++)
         if (!m[l])
            mem_exp[a][9*l+:9] = d[9*l+:9];
      chk_oe(4'h0);
      chk({35'h0, buf_ready}, 36'h1);
      drain();
   endtask

   task automatic s_lanes();
      wr1(10'h155, 4'h0, 36'h912345678);
      rd(10'h155);
      wr1(10'h2C3, 4'h0, pat(10'h2C3, 9'h000));
      for (int l = 0; l < 5; l++) begin
         wr1(10'h2C3, (l < 4) ? ~(4'h1 << l) : 4'hF, {4{9'(l) ^ 9'h1E7}});
         rd(10'h2C3);
      end
   endtask

   task automatic s_burst(input logic [9:0] a, input logic [8:0] s);
      host.issue(WR, a, 4'h0);
      for (int k = 1; k < 5; k++) begin
         host.issue((k < 4) ? ST : DS, a, 4'h0, 1'b1, pat(baddr(a, k - 1), s));
         mem_exp[baddr(a, k - 1)] = pat(baddr(a, k - 1), s);
      end
      drain();
      rd(a);
      for (int k = 1; k < 6; k++) begin
         host.issue(ST, a, 4'hF);
         chk(lanes, mem_exp[baddr(a, k)]);
      end
   endtask

   // Write burst whose second beat is aborted by all lanes high
   task automatic s_cont_abort();
      host.issue(WR, 10'h0A4, 4'h0);
      host.issue(ST, 10'h0A4, 4'hF, 1'b1, pat(10'h0A4, 9'h111));
      chk_oe(4'h0);
      host.issue(ST, 10'h0A4, 4'h0, 1'b1, 36'h0);
      host.issue(DS, 10'h0A4, 4'h0, 1'b1, pat(10'h0A6, 9'h111));
      mem_exp[10'h0A4] = pat(10'h0A4, 9'h111);
      mem_exp[10'h0A6] = pat(10'h0A6, 9'h111);
      drain();
      rd(10'h0A4);
      host.issue(ST, 10'h0A4, 4'hF);
      chk(lanes, mem_exp[10'h0A5]);
      host.issue(ST, 10'h0A4, 4'hF);
      chk(lanes, mem_exp[10'h0A6]);
   endtask

   task automatic s_stall();
      rd(10'h0A5);
      host.issue(ST, 10'h0, 4'hF, 1'b0, 36'h0, 1'b1);
      chk_oe(4'hF);
      clk_en = 1'b0;
      host.issue(ST, 10'h0, 4'hF);
      clk_en = 1'b1;
      host.issue(ST, 10'h0, 4'hF);
      chk(lanes, mem_exp[baddr(10'h0A5, 1)]);
      host.issue(WR, 10'h0A6, 4'h0);
      host.issue(DS, 10'h0, 4'h0, 1'b1, 36'h0F0F0F0F0, 1'b1);
      chk_oe(4'h0);
      host.issue(DS, 10'h0, 4'h0, 1'b1, 36'h0F0F0F0F0);
      mem_exp[10'h0A6] = 36'h0F0F0F0F0;
      drain();
      rd(10'h0A6);
   endtask

   task automatic s_oe_sleep();
      rd(10'h155);
      oe_n = 1'b1;
      #1 chk_oe(4'h0);
      @(posedge sys_clk);
      #1;
      host.issue(RD, 10'h155, 4'hF);
      chk_oe(4'h0);
      oe_n = 1'b0;
      rd(10'h155);
      host.put(ST, 10'h0, 4'hF, 1'b0, 36'h0, 1'b1);
      sleep_req = 1'b1;
      #1 chk_oe(4'h0);
      @(posedge sys_clk);
      #1;
      host.issue(ST, 10'h0, 4'hF, 1'b0, 36'h0, 1'b1);
      repeat (2) host.issue(RD, 10'h2C3, 4'hF);
      sleep_req = 1'b0;
      // Only stalls while waking
      repeat (3) host.issue(ST, 10'h0, 4'hF, 1'b0, 36'h0, 1'b1);
      chk_oe(4'hF);
      chk(lanes, mem_exp[10'h155]);
   endtask

   task automatic s_desel();
      for (int v = 0; v < 3; v++) begin
         rd(10'h155);
         host.issue(DS, 10'h155, 4'(v));
         chk_oe(4'h0);
         host.issue(ST, 10'h155, 4'h0);
         chk_oe(4'h0);
      end
   endtask

   // Reset with the strap already at its board level
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (16) @(posedge sys_clk);
      #1 chk_oe(4'h0);
      rst_n = 1'b1;
      repeat (2) host.issue(DS, 10'h0, 4'h0);
   endtask

   // Hang guard
   initial begin
      #200000;
      fail_count++;
      final_report();
   end

   // Main sequence
   initial begin
      host.put(DS, 10'h0, 4'h0, 1'b0, 36'h0, 1'b0);
      do_reset();
      s_lanes();
      s_burst(10'h0A5, 9'h033);
      s_cont_abort();
      s_stall();
      s_oe_sleep();
      s_desel();
      order_n = 1'b1;
      do_reset();
      s_burst(10'h0A5, 9'h0C6);
      final_report();
   end
endmodule
